// file: verilog/adc_scan_pkg.sv
// Constants for the converter control scan cells
package adc_scan_pkg;
   localparam int unsigned MUX_W      = 8;
   localparam int unsigned NEG_W      = 3;
   localparam int unsigned DAC_W      = 10;
   // Cell positions in the control chain, bit 0 nearest the scan input
   localparam int unsigned POS_GND    = 0;
   localparam int unsigned POS_HOLD   = 1;
   localparam int unsigned POS_PASS   = 2;
   localparam int unsigned POS_COMPARATOR_LATCH_PRECHARGE_N  = 3;
   localparam int unsigned POS_ACLK   = 4;
   localparam int unsigned POS_NEG    = 5;
   localparam int unsigned POS_MUX    = 8;
   localparam int unsigned POS_DAC    = 16;
   localparam int unsigned CHAIN_W    = 26;
   // Idle values, held while the converter is not under test
   localparam logic               IDLE_GND   = 1'h0;
   localparam logic               IDLE_HOLD  = 1'h1;
   localparam logic               IDLE_PASS  = 1'h1;
   localparam logic               IDLE_COMPARATOR_LATCH_PRECHARGE_N = 1'h1;
   localparam logic               IDLE_ACLK  = 1'h0;
   localparam logic [NEG_W-1:0]   IDLE_NEG   = 3'h0;
   localparam logic [MUX_W-1:0]   IDLE_MUX   = 8'h01;
   localparam logic [DAC_W-1:0]   IDLE_DAC   = 10'h200;
   localparam logic [CHAIN_W-1:0] IDLE_CHAIN = {IDLE_DAC, IDLE_MUX,
      IDLE_NEG, IDLE_ACLK, IDLE_COMPARATOR_LATCH_PRECHARGE_N, IDLE_PASS, IDLE_HOLD, IDLE_GND};
endpackage

// file: verilog/scan_cell.sv
// One boundary-scan cell: capture/shift stage and update latch
`timescale 1ns/1ps
`default_nettype none
module scan_cell #(
   parameter logic IDLE = 1'h0                 // Update value after reset
) (
   input  wire logic i_clk_sys,                // System clock
   input  wire logic i_rst_n,                  // Async reset, active low
   input  wire logic i_shift,                  // Shift-DR phase
   input  wire logic i_capture,                // Capture-DR phase
   input  wire logic i_update,                 // Update-DR strobe
   input  wire logic i_scan_in,                // From previous cell
   input  wire logic i_observe,                // Value to capture
   output logic      o_scan_out,               // Shift stage
   output logic      o_cell                    // Update stage
);
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_scan_out <= IDLE;
      end else if (i_shift) begin
         o_scan_out <= i_scan_in;
      end else if (i_capture) begin
         o_scan_out <= i_observe;
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_cell <= IDLE;
      end else if (i_update) begin
         o_cell <= o_scan_out;
      end
   end
endmodule
`default_nettype wire

// file: verilog/adc_scan_control_cells.sv
// Scan cells that drive the converter control inputs during test
`timescale 1ns/1ps
`default_nettype none
module adc_scan_control_cells (
   input  wire logic                            i_clk_sys,   // 20 MHz clock
   input  wire logic                            i_rst_n,     // Async reset
   input  wire logic                            i_test_mode, // Chain owns ADC
   input  wire logic                            i_shift,     // Shift-DR
   input  wire logic                            i_capture,   // Capture-DR
   input  wire logic                            i_update,    // Update-DR
   input  wire logic                            i_tdi,       // Scan in
   output logic                                 o_tdo,       // Scan out
   output logic                                 o_ground_negative_input,
   output logic                                 o_hold,      // 1 hold 0 samp
   output logic                                 o_gain_pass_gate_enable,
   output logic                                 o_comparator_latch_precharge_n,
   output logic                                 o_gain_clock, // Switch-cap
   output logic [adc_scan_pkg::NEG_W-1:0]       o_negative_input_select,
   output logic [adc_scan_pkg::MUX_W-1:0]       o_input_channel_select,
   output logic [adc_scan_pkg::DAC_W-1:0]       o_dac_value  // DAC code
);
   import adc_scan_pkg::*;

   logic [CHAIN_W-1:0] shift_st;
   logic [CHAIN_W-1:0] cell_st;
   logic [CHAIN_W-1:0] chain_in;
   logic [CHAIN_W-1:0] drive_d;

   // Refuse a chain layout that the field slices cannot serve
   if (POS_DAC + DAC_W != CHAIN_W) begin : g_bad_len
      $error("control chain length does not match its fields");
   end
   if (POS_MUX + MUX_W > POS_DAC) begin : g_bad_mux
      $error("channel field overlaps the DAC field");
   end
   if (POS_NEG + NEG_W > POS_MUX) begin : g_bad_neg
      $error("negative select field overlaps the channel field");
   end
   if (POS_ACLK >= POS_NEG) begin : g_bad_aclk
      $error("single-bit cells overlap the negative select field");
   end
   if (CHAIN_W < 2) begin : g_bad_short
      $error("control chain too short to shift");
   end

   // Chain input: TDI into bit 0, each cell feeds the next
   assign chain_in = {shift_st[CHAIN_W-2:0], i_tdi};

   // Capture reads back what is applied, so a scan-out checks the drive
   genvar g;
   generate
      for (g = 0; g < CHAIN_W; g++) begin : g_cell
         scan_cell #(
            .IDLE (IDLE_CHAIN[g])
         ) u_cell (
            .i_clk_sys  (i_clk_sys),
            .i_rst_n    (i_rst_n),
            .i_shift    (i_shift),
            .i_capture  (i_capture),
            .i_update   (i_update),
            .i_scan_in  (chain_in[g]),
            .i_observe  (drive_d[g]),
            .o_scan_out (shift_st[g]),
            .o_cell     (cell_st[g])
         );
      end
   endgenerate

   // Idle values whenever the converter is not under test
   // DAC idle midpoint
   assign drive_d = i_test_mode ? cell_st : IDLE_CHAIN;

   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_tdo <= 1'h0;
      end else begin
         o_tdo <= shift_st[CHAIN_W-1];
      end
   end

   // Outputs registered so the analog side sees no decode glitches
   // Ground negative input
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_ground_negative_input <= IDLE_GND;
      end else begin
         o_ground_negative_input <= drive_d[POS_GND];
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_hold <= IDLE_HOLD;
      end else begin
         o_hold <= drive_d[POS_HOLD];
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_gain_pass_gate_enable <= IDLE_PASS;
      end else begin
         o_gain_pass_gate_enable <= drive_d[POS_PASS];
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_comparator_latch_precharge_n <= IDLE_COMPARATOR_LATCH_PRECHARGE_N;
      end else begin
         o_comparator_latch_precharge_n <= drive_d[POS_COMPARATOR_LATCH_PRECHARGE_N];
      end
   end

   // Gain clock idles low so the switched-capacitor stages stay still
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_gain_clock <= IDLE_ACLK;
      end else begin
         o_gain_clock <= drive_d[POS_ACLK];
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_negative_input_select <= IDLE_NEG;
      end else begin
         o_negative_input_select <= drive_d[POS_NEG +: NEG_W];
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_input_channel_select <= IDLE_MUX;
      end else begin
         o_input_channel_select <= drive_d[POS_MUX +: MUX_W];
      end
   end

   // Midpoint while sampling is tester's duty
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_dac_value <= IDLE_DAC;
      end else begin
         o_dac_value <= drive_d[POS_DAC +: DAC_W];
      end
   end
endmodule
`default_nettype wire

// file: dv/adc_scan_control_cells_checker.sv
// Assertions on the converter control scan cell outputs
`timescale 1ns/1ps
`default_nettype none
module adc_scan_control_cells_checker import adc_scan_pkg::*; (
   input wire logic             i_clk_sys, i_rst_n, i_test_mode, i_update,
   input wire logic             o_ground_negative_input, o_hold,
   input wire logic             o_gain_pass_gate_enable, o_gain_clock,
   input wire logic             o_comparator_latch_precharge_n,
   input wire logic [NEG_W-1:0] o_negative_input_select,
   input wire logic [MUX_W-1:0] o_input_channel_select,
   input wire logic [DAC_W-1:0] o_dac_value
);
   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (!i_rst_n);
   // Two low samples cover either test mode latency
   sequence idle_req; !i_test_mode ##1 !i_test_mode ##1 1'b1; endsequence
   sequence quiet; (i_test_mode && !i_update) [*4]; endsequence
   chk_gnd_idle: assert property (
      idle_req |-> !o_ground_negative_input)
      else $error("ground cell not idle");
   chk_hold_idle: assert property (
      idle_req |-> o_hold)
      else $error("hold cell not idle");
   chk_neg_idle: assert property (
      idle_req |-> o_negative_input_select == 3'h0)
      else $error("negative select not idle");
   chk_pass_idle: assert property (
      idle_req |-> o_gain_pass_gate_enable)
      else $error("pass gate not idle");
   chk_comparator_latch_precharge_n_idle: assert property (
      idle_req |-> o_comparator_latch_precharge_n)
      else $error("precharge not idle");
   chk_mux_idle: assert property (
      idle_req |-> o_input_channel_select == 8'h01)
      else $error("channel select not idle");
   chk_dac_idle: assert property (
      idle_req |-> o_dac_value == 10'h200)
      else $error("dac value not idle");
   chk_cells_hold: assert property (
      quiet |-> $stable({o_dac_value, o_hold, o_input_channel_select,
         o_negative_input_select, o_ground_negative_input,
         o_gain_pass_gate_enable, o_comparator_latch_precharge_n,
         o_gain_clock}))
      else $error("cells moved without update");
endmodule
bind adc_scan_control_cells adc_scan_control_cells_checker u_chk (.*);
`default_nettype wire

// file: dv/scan_tester.sv
// Model of the test controller that drives the control chain
`timescale 1ns/1ps
`default_nettype none
module scan_tester import adc_scan_pkg::*; (
   input  wire logic i_clk_sys, // Bench clock
   input  wire logic i_tdo,     // Chain out
   output logic      o_shift,   // Shift-DR
   output logic      o_capture, // Capture-DR
   output logic      o_update,  // Update-DR
   output logic      o_tdi      // Chain in
);
   initial {o_shift, o_capture, o_update, o_tdi} = 4'h0;
   task automatic load(input  logic [CHAIN_W-1:0] v,
                       output logic [CHAIN_W-1:0] w);
      w = v;
      // sampling with gain clock high, mid DAC
      if (!w[POS_HOLD]) {w[POS_DAC+:DAC_W], w[POS_ACLK]} = {10'h200, 1'h1};
      for (int i = CHAIN_W - 1; i >= 0; i--) begin
         {o_shift, o_tdi} = {1'h1, w[i]};
         @(negedge i_clk_sys);
      end
      {o_shift, o_update, o_tdi} = {2'h1, ~o_tdi};
      @(negedge i_clk_sys);
      o_update = 1'h0;
   endtask
   task automatic unload(output logic [CHAIN_W-1:0] got);
      o_capture = 1'h1;
      @(negedge i_clk_sys);
      {o_capture, o_shift} = 2'h1;
      for (int i = 0; i < CHAIN_W; i++) begin
         @(negedge i_clk_sys);
         got = {got[CHAIN_W-2:0], i_tdo};
         o_tdi = ~o_tdi;
      end
      o_shift = 1'h0;
   endtask
endmodule
`default_nettype wire

// file: dv/adc_scan_control_cells_tb_top.sv
// Self-checking bench for the converter control scan cells
`timescale 1ns/1ps
`default_nettype none
module adc_scan_control_cells_tb_top;
   import adc_scan_pkg::*;
   logic                   clk = 1'h0, rst_n = 1'h0, tm = 1'h0;
   wire logic              sh, ca, up, tdi, tdo, gnd, hold, pass, comparator_latch_precharge_n, aclk;
   wire logic [NEG_W-1:0]  neg;
   wire logic [MUX_W-1:0]  mux;
   wire logic [DAC_W-1:0]  dac;
   wire logic [CHAIN_W-1:0] outs = {dac, mux, neg, aclk, comparator_latch_precharge_n, pass, hold,
                                    gnd};
   logic [CHAIN_W-1:0]     exp_q[$], want, got;
   int                     mismatches = 0, n_checks = 0;
   always #25 clk = ~clk;
   scan_tester u_tst (.i_clk_sys(clk), .i_tdo(tdo), .o_shift(sh),
      .o_capture(ca), .o_update(up), .o_tdi(tdi));
   adc_scan_control_cells uut (.i_clk_sys(clk), .i_rst_n(rst_n),
      .i_test_mode(tm), .i_shift(sh), .i_capture(ca), .i_update(up),
      .i_tdi(tdi), .o_tdo(tdo), .o_ground_negative_input(gnd), .o_hold(hold),
      .o_gain_pass_gate_enable(pass), .o_comparator_latch_precharge_n(comparator_latch_precharge_n),
      .o_gain_clock(aclk), .o_negative_input_select(neg),
      .o_input_channel_select(mux), .o_dac_value(dac));
   task automatic chk(input logic [CHAIN_W-1:0] seen, exp);
      n_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic complete_run;
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   initial begin
      repeat (4000) @(posedge clk);
      mismatches++;
      complete_run;
   end
   initial begin
      want = CHAIN_W'($urandom(33));
      repeat (4) @(negedge clk);
      rst_n = 1'h1;
      chk(outs, IDLE_CHAIN);
      tm = 1'h1;
      repeat (24) begin
         u_tst.load(CHAIN_W'($urandom), want);
         exp_q.push_back(want);
         @(negedge clk);
         chk(outs, exp_q.pop_front());
      end
      u_tst.unload(got);
      chk(got, want);
      tm = 1'h0;
      repeat (2) @(negedge clk);
      chk(outs, IDLE_CHAIN);
      tm = 1'h1;
      repeat (2) @(negedge clk);
      chk(outs, want);
      rst_n = 1'h0;
      @(negedge clk);
      chk(outs, IDLE_CHAIN);
      rst_n = 1'h1;
      repeat (2) @(negedge clk);
      chk(outs, IDLE_CHAIN);
      tm = 1'h0;
      u_tst.unload(got);
      chk(got, IDLE_CHAIN);
      complete_run;
   end
endmodule
`default_nettype wire
